// *** hdl/spiwp_top.sv ***
// serial front end with status register and write protection
`timescale 1ns/1ps
`include "spiwp_regs.svh"
module spiwp_top #(
  parameter int WRITE_CYCLES = `SPIWP_WRITE_CYCLES,
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe,
  output logic busy,
  output logic arr_wr_go,
  output logic [7:0] arr_wr_addr,
  output logic wr_data_valid,
  input wire logic wr_data_ready,
  output logic [FIFO_WIDTH-1:0] wr_data,
  output logic wr_data_dropped
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);

  // synchronised pin levels
  logic cs_n_s; // select level
  logic sck_s; // serial clock level
  logic si_s; // serial input level
  logic hold_n_s; // hold level
  logic wp_n_s; // protect pin level

  spiwp_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .clk(clk), .rst_n(rst_n), .async_in(cs_n), .level(cs_n_s));
  spiwp_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .clk(clk), .rst_n(rst_n), .async_in(sck), .level(sck_s));
  spiwp_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .clk(clk), .rst_n(rst_n), .async_in(si), .level(si_s));
  spiwp_sync #(.RESET_VAL(1'b1)) u_sync_hold (
    .clk(clk), .rst_n(rst_n), .async_in(hold_n), .level(hold_n_s));
  spiwp_sync #(.RESET_VAL(1'b1)) u_sync_wp (
    .clk(clk), .rst_n(rst_n), .async_in(wp_n), .level(wp_n_s));

  // edge detection state
  logic sck_prev_reg; // last clock level
  logic cs_prev_reg; // last select level
  logic sck_rise; // qualified rising edge
  logic sck_fall; // qualified falling edge
  logic cs_fall; // select asserted
  logic cs_rise; // select released

  // sequence state
  spiwp_pkg::spiwp_state_type state_reg; // serial sequence state
  logic [2:0] bit_cnt_reg; // bit within byte
  logic [7:0] shift_reg; // incoming byte
  logic [7:0] out_byte_reg; // status image being shifted out
  logic [2:0] op_reg; // decoded opcode low bits
  logic op_done_reg; // opcode with no data phase received while not busy
  logic stat_byte_reg; // status data byte complete
  logic [7:0] stat_new_reg; // received status data
  logic ar_ok_reg; // array write allowed for this address
  logic ar_byte_reg; // at least one array byte taken

  // status and write cycle state
  logic wel_reg; // write latch
  logic [1:0] bp_reg; // block protect level
  logic arm_reg; // hardware protect arm
  logic busy_reg; // internal write running
  logic [TW-1:0] timer_reg; // write cycle counter
  logic pend_st_reg; // status update at cycle end
  logic [2:0] pend_val_reg; // arm and protect bits to store
  logic [7:0] addr_reg; // array address

  logic hw_prot; // hardware protection active
  logic [7:0] status_image; // value shown on read
  logic byte_end; // eighth bit sampled
  logic [7:0] byte_full; // completed byte
  logic addr_protected; // address falls in protected block
  logic push_valid; // array byte to buffer
  logic push_ready; // buffer can take it

  // edge detection, hold masks the clock
  assign sck_rise = !cs_n_s && hold_n_s && sck_s && !sck_prev_reg;
  assign sck_fall = !cs_n_s && hold_n_s && !sck_s && sck_prev_reg;
  assign cs_fall = !cs_n_s && cs_prev_reg;
  assign cs_rise = cs_n_s && !cs_prev_reg;
  assign byte_end = sck_rise && (bit_cnt_reg == 3'h7);
  assign byte_full = {shift_reg[6:0], si_s};

  // protection decode
  assign hw_prot = !wp_n_s && arm_reg;
  always_comb begin
    unique case (bp_reg)
      2'h0: addr_protected = 1'b0;
      2'h1: addr_protected = (byte_full >= `SPIWP_QUARTER_BASE);
      2'h2: addr_protected = (byte_full >= `SPIWP_HALF_BASE);
      2'h3: addr_protected = 1'b1; // whole array
    endcase
  end

  // status image, all ones while writing
  always_comb begin
    status_image = 8'h00;
    status_image[`SPIWP_WEL_BIT] = wel_reg;
    status_image[`SPIWP_BP_HI_BIT:`SPIWP_BP_LO_BIT] = bp_reg;
    status_image[`SPIWP_ARM_BIT] = arm_reg;
    if (busy_reg) begin
      status_image = `SPIWP_BUSY_IMAGE;
    end
  end

  // edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_n_s;
    end
  end

  // serial sequence; mode 0 and mode 3 both start at a rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= spiwp_pkg::SPIWP_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      op_reg <= 3'h0;
      op_done_reg <= 1'b0;
      stat_byte_reg <= 1'b0;
      stat_new_reg <= 8'h00;
      ar_ok_reg <= 1'b0;
      ar_byte_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (cs_n_s) begin
      state_reg <= spiwp_pkg::SPIWP_IDLE;
      bit_cnt_reg <= 3'h0;
    end else begin
      if (cs_fall) begin
        state_reg <= spiwp_pkg::SPIWP_OPCODE;
        bit_cnt_reg <= 3'h0;
        op_done_reg <= 1'b0;
        stat_byte_reg <= 1'b0;
        ar_ok_reg <= 1'b0;
        ar_byte_reg <= 1'b0;
      end else if (sck_rise) begin
        shift_reg <= byte_full;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        unique case (state_reg)
          spiwp_pkg::SPIWP_IDLE: begin
            state_reg <= spiwp_pkg::SPIWP_IDLE;
          end
          spiwp_pkg::SPIWP_OPCODE: begin
            if (byte_end) begin
              op_reg <= byte_full[2:0];
              if (byte_full[7:4] != `SPIWP_OP_HI) begin
                state_reg <= spiwp_pkg::SPIWP_IDLE; // unsupported, ignore
              end else if (byte_full[2:0] == `SPIWP_OP_RD_STATUS) begin
                state_reg <= spiwp_pkg::SPIWP_STOUT; // allowed while busy
              end else if (busy_reg) begin
                state_reg <= spiwp_pkg::SPIWP_IDLE;
              end else if (byte_full[2:0] == `SPIWP_OP_WR_STATUS) begin
                state_reg <= spiwp_pkg::SPIWP_STDATA;
              end else if (byte_full[2:0] == `SPIWP_OP_WR_ARRAY) begin
                state_reg <= spiwp_pkg::SPIWP_ADDR;
              end else begin
                op_done_reg <= 1'b1; // latch commands act at select rise
                state_reg <= spiwp_pkg::SPIWP_IDLE;
              end
            end
          end
          spiwp_pkg::SPIWP_STDATA: begin
            if (byte_end) begin
              stat_new_reg <= byte_full;
              stat_byte_reg <= 1'b1;
              state_reg <= spiwp_pkg::SPIWP_IDLE; // further bits ignored
            end
          end
          spiwp_pkg::SPIWP_STOUT: begin
            state_reg <= spiwp_pkg::SPIWP_STOUT;
          end
          spiwp_pkg::SPIWP_ADDR: begin
            if (byte_end) begin
              addr_reg <= byte_full;
              ar_ok_reg <= wel_reg && !addr_protected;
              state_reg <= spiwp_pkg::SPIWP_ARDATA;
            end
          end
          spiwp_pkg::SPIWP_ARDATA: begin
            if (byte_end && ar_ok_reg) begin
              ar_byte_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // array bytes into the buffer when the write may proceed
  assign push_valid = (state_reg == spiwp_pkg::SPIWP_ARDATA) && byte_end && ar_ok_reg;

  spiwp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(byte_full[FIFO_WIDTH-1:0]),
    .out_valid(wr_data_valid),
    .out_ready(wr_data_ready),
    .out_data(wr_data)
  );

  // sticky drop flag when the buffer is full, cleared at next select fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_data_dropped <= 1'b0;
    end else if (push_valid && !push_ready) begin
      wr_data_dropped <= 1'b1;
    end else if (cs_fall) begin
      wr_data_dropped <= 1'b0;
    end
  end

  // serial output: status byte repeats, shifted on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_out <= 1'b0;
      out_byte_reg <= 8'h00;
    end else if (state_reg == spiwp_pkg::SPIWP_STOUT && sck_fall) begin
      if (bit_cnt_reg == 3'h0) begin
        out_byte_reg <= {status_image[6:0], 1'b0}; // fresh snapshot
        so_out <= status_image[7];
      end else begin
        out_byte_reg <= {out_byte_reg[6:0], 1'b0};
        so_out <= out_byte_reg[7];
      end
    end
  end

  // drive only in output phase, select low and not held
  assign so_oe = !cs_n_s && hold_n_s && (state_reg == spiwp_pkg::SPIWP_STOUT);

  // write latch, protect bits, write cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg <= `SPIWP_WEL_RESET;
      bp_reg <= `SPIWP_BP_RESET;
      arm_reg <= `SPIWP_ARM_RESET;
      busy_reg <= 1'b0;
      timer_reg <= '0;
      pend_st_reg <= 1'b0;
      pend_val_reg <= 3'h0;
      arr_wr_go <= 1'b0;
      arr_wr_addr <= 8'h00;
    end else begin
      arr_wr_go <= 1'b0;
      if (busy_reg) begin
        if (timer_reg != '0) begin
          timer_reg <= timer_reg - TW'(1);
        end else if (!wr_data_valid) begin
          busy_reg <= 1'b0; // cycle ends once buffer drained
          pend_st_reg <= 1'b0;
          if (pend_st_reg) begin
            arm_reg <= pend_val_reg[2];
            bp_reg <= pend_val_reg[1:0];
          end
        end
      end else if (cs_rise) begin
        if (op_done_reg && op_reg == `SPIWP_OP_SET_LATCH) begin
          wel_reg <= 1'b1;
        end else if (op_done_reg && op_reg == `SPIWP_OP_CLR_LATCH) begin
          wel_reg <= 1'b0;
        end else if (stat_byte_reg && wel_reg && !hw_prot) begin
          wel_reg <= 1'b0;
          busy_reg <= 1'b1;
          timer_reg <= TW'(WRITE_CYCLES);
          pend_st_reg <= 1'b1;
          pend_val_reg <= {stat_new_reg[`SPIWP_ARM_BIT],
                           stat_new_reg[`SPIWP_BP_HI_BIT:`SPIWP_BP_LO_BIT]};
        end else if (ar_byte_reg) begin
          wel_reg <= 1'b0;
          busy_reg <= 1'b1;
          timer_reg <= TW'(WRITE_CYCLES);
          arr_wr_go <= 1'b1;
          arr_wr_addr <= addr_reg;
        end
      end
    end
  end

  assign busy = busy_reg;
endmodule

// *** hdl/spiwp_regs.svh ***
// offsets, field positions, reset values and timing counts of the protect front end
`ifndef SPIWP_REGS_SVH
`define SPIWP_REGS_SVH

// status register field positions
`define SPIWP_BUSY_BIT 0
`define SPIWP_WEL_BIT 1
`define SPIWP_BP_LO_BIT 2
`define SPIWP_BP_HI_BIT 3
`define SPIWP_ARM_BIT 7

// factory and reset values, and the status image shown while busy
`define SPIWP_BP_RESET 2'h0
`define SPIWP_ARM_RESET 1'h0
`define SPIWP_WEL_RESET 1'h0
`define SPIWP_BUSY_IMAGE 8'hFF

// opcode fields: upper nibble zero, bit 3 ignored, low three bits select
`define SPIWP_OP_HI 4'h0
`define SPIWP_OP_SET_LATCH 3'h6
`define SPIWP_OP_CLR_LATCH 3'h4
`define SPIWP_OP_RD_STATUS 3'h5
`define SPIWP_OP_WR_STATUS 3'h1
`define SPIWP_OP_RD_ARRAY 3'h3
`define SPIWP_OP_WR_ARRAY 3'h2

// protected region starts per level
`define SPIWP_QUARTER_BASE 8'hC0
`define SPIWP_HALF_BASE 8'h80

// self-timed write: time in ns, clock 50 MHz
`define SPIWP_CLK_MHZ 50
`define SPIWP_WRITE_TIME_NS 4000000
`define SPIWP_WRITE_CYCLES ((`SPIWP_WRITE_TIME_NS / 1000) * `SPIWP_CLK_MHZ)

`endif

// *** hdl/spiwp_pkg.sv ***
// types of the protect front end
package spiwp_pkg;

  // serial sequence states, one-hot
  typedef enum logic [5:0] {
    SPIWP_IDLE   = 6'h01,
    SPIWP_OPCODE = 6'h02,
    SPIWP_STDATA = 6'h04,
    SPIWP_STOUT  = 6'h08,
    SPIWP_ADDR   = 6'h10,
    SPIWP_ARDATA = 6'h20
  } spiwp_state_type;

endpackage

// *** hdl/spiwp_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module spiwp_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level
);
  logic ff1_reg; // first stage, read only by the second
  logic ff2_reg; // second stage
  logic ff3_reg; // third stage

  // shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_reg <= RESET_VAL;
      ff2_reg <= RESET_VAL;
      ff3_reg <= RESET_VAL;
    end else begin
      ff1_reg <= async_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // level follows only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= RESET_VAL;
    end else if (ff2_reg == ff3_reg) begin
      level <= ff3_reg;
    end
  end
endmodule

// *** hdl/spiwp_fifo.sv ***
// write data buffer between serial side and array side
`timescale 1ns/1ps
module spiwp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH]; // storage
  logic [AW-1:0] wr_ptr_reg; // write index
  logic [AW-1:0] rd_ptr_reg; // read index
  logic [AW:0] count_reg; // fill level
  logic push; // accepted write
  logic pop; // accepted read

  assign in_ready = (count_reg != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

// *** tb/spiwp_monitor.sv ***
// assertions on the ports of the protect front end
`timescale 1ns/1ps
module spiwp_monitor #(
  parameter int WRITE_CYCLES = 200000,
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic arr_wr_go,
  input wire logic [7:0] arr_wr_addr,
  input wire logic wr_data_valid,
  input wire logic wr_data_ready,
  input wire logic [FIFO_WIDTH-1:0] wr_data,
  input wire logic wr_data_dropped
);
  int busy_cnt; // cycles the write has run
  // length of the current busy stretch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt <= 0;
    else busy_cnt <= busy ? busy_cnt + 1 : 0;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // select parked high long enough to reach the logic
  sequence s_desel;
    cs_n [*8];
  endsequence
  // transfer paused long enough to reach the logic
  sequence s_held;
    !hold_n [*8];
  endsequence
  a_oe_off_desel: assert property (s_desel |-> !so_oe)
    else $error("output driven while deselected");
  a_oe_off_hold: assert property (s_held |-> !so_oe)
    else $error("output driven while held");
  a_oe_rise_sel: assert property ($rose(so_oe) |-> !cs_n && hold_n)
    else $error("output enabled outside a frame");
  a_go_pulse: assert property (arr_wr_go |=> !arr_wr_go)
    else $error("write start longer than one cycle");
  a_go_after_sel: assert property (arr_wr_go |-> $past(cs_n, 3) ##[0:1] busy)
    else $error("write start without select rise");
  a_busy_no_sel: assert property ($rose(busy) |-> cs_n)
    else $error("write cycle began inside a frame");
  a_busy_span: assert property ($fell(busy) |-> busy_cnt >= WRITE_CYCLES - 1)
    else $error("write cycle too short");
  a_drain_done: assert property ($fell(busy) |-> !wr_data_valid)
    else $error("ready with bytes still buffered");
  a_head_stable: assert property (wr_data_valid && !wr_data_ready
    |=> wr_data_valid && $stable(wr_data))
    else $error("buffer head changed while stalled");
  a_so_move_oe: assert property ($changed(so_out) |-> $past(so_oe))
    else $error("output bit moved while not driven");
  a_addr_with_go: assert property ($changed(arr_wr_addr) |-> arr_wr_go)
    else $error("write address changed without write start");
  a_drop_in_frame: assert property ($rose(wr_data_dropped) |-> !cs_n)
    else $error("dropped byte reported outside a frame");
endmodule
bind spiwp_top spiwp_monitor #(.WRITE_CYCLES(WRITE_CYCLES), .FIFO_WIDTH(FIFO_WIDTH),
  .FIFO_DEPTH(FIFO_DEPTH)) u_mon (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
  .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .busy(busy),
  .arr_wr_go(arr_wr_go), .arr_wr_addr(arr_wr_addr), .wr_data_valid(wr_data_valid),
  .wr_data_ready(wr_data_ready), .wr_data(wr_data), .wr_data_dropped(wr_data_dropped));

// *** tb/spiwp_master.sv ***
// spi master model driving select, clock, data and hold
`timescale 1ns/1ps
module spiwp_master (
  input wire logic clk,
  input wire logic so_out,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  logic cpol; // idle clock level, 1 for mode three
  // pins idle at time zero
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    cpol = 1'b0;
  end
  // wait n falling clock edges
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // select edge with clock parked at its idle level
  task automatic sel(input logic on);
    sck = cpol;
    tk(4);
    cs_n = ~on;
    si = ~si; // no stale value on a released line
    tk(8);
  endtask
  // one byte msb first, pausing before bit hb
  task automatic xfer(input logic [7:0] tx, input int hb, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      tk(4);
      if (i == hb) begin
        hold_n = 1'b0;
        tk(6);
        repeat (3) begin
          sck = 1'b1;
          tk(4);
          sck = 1'b0;
          tk(4);
        end
        hold_n = 1'b1;
        tk(6);
      end
      sck = 1'b1;
      tk(4);
      rx[i] = so_out;
    end
  endtask
endmodule

// *** tb/spiwp_tb_top.sv ***
// self-checking bench of the protect front end
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module spiwp_tb_top;
  localparam int WC = 1000; // shortened write time
  logic clk, rst_n, wp_n, cs_n, sck, si, hold_n, so_out, so_oe, busy, go, wvalid, drop;
  logic rdy = 1'b0; // array side ready, every other cycle while rdy_on
  logic rdy_on; // array side willing to take bytes
  logic [7:0] waddr, wdata, rx;
  logic [7:0] adr [6] = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFF}; // level edges
  logic [7:0] got[$]; // bytes taken by the array side
  int err_total, checked, cyc, gos, g;
  spiwp_top #(.WRITE_CYCLES(WC)) DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .busy(busy),
    .arr_wr_go(go), .arr_wr_addr(waddr), .wr_data_valid(wvalid), .wr_data_ready(rdy),
    .wr_data(wdata), .wr_data_dropped(drop));
  spiwp_master mst (.clk(clk), .so_out(so_out), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n));
  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // array side ready at half rate, so the buffer sees back-pressure too
  always @(negedge clk) begin
    rdy <= (rdy_on === 1'b1) && (rdy !== 1'b1);
  end
  // counts, array side sink and hang limit
  always @(posedge clk) begin
    cyc++;
    if (go === 1'b1) gos++;
    if (wvalid === 1'b1 && rdy === 1'b1) got.push_back(wdata);
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end
  // address falls inside the protected blocks
  function automatic logic prot(input int lv, input logic [7:0] a);
    return (lv == 3) || (lv == 2 && a >= 8'h80) || (lv == 1 && a >= 8'hC0);
  endfunction
  // one-byte command frame
  task automatic cmd(input logic [7:0] op);
    mst.sel(1'b1);
    mst.xfer(op, -1, rx);
    mst.sel(1'b0);
  endtask
  // status read of two bytes, hold before bit hb of the second
  task automatic read_status(input logic [7:0] exp, input int hb);
    mst.sel(1'b1);
    mst.xfer(8'h05, -1, rx);
    mst.xfer(8'h00, -1, rx);
    `CHK(rx, exp)
    mst.xfer(8'h00, hb, rx);
    `CHK(rx, exp)
    mst.sel(1'b0);
    `CHK(so_oe, 1'b0)
  endtask
  // status write, latch set first when en
  task automatic write_status(input logic en, input logic [7:0] v);
    if (en) cmd(8'h06);
    mst.sel(1'b1);
    mst.xfer(8'h01, -1, rx);
    mst.xfer(v, -1, rx);
    mst.sel(1'b0);
  endtask
  // array write of n bytes counting up from 30
  task automatic awr(input logic [7:0] a, input int n);
    cmd(8'h06);
    mst.sel(1'b1);
    mst.xfer(8'h02, -1, rx);
    mst.xfer(a, -1, rx);
    for (int i = 0; i < n; i++) mst.xfer(8'h30 + 8'(i), -1, rx);
    mst.sel(1'b0);
  endtask
  // bounded wait for the write cycle to end
  task automatic wait_rdy;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK(busy, 1'b0)
  endtask
  // verdict and end of run
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    rdy_on <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    read_status(8'h00, -1);
    mst.cpol = 1'b1;
    cmd(8'h06);
    read_status(8'h02, -1);
    cmd(8'h04);
    read_status(8'h00, -1);
    mst.cpol = 1'b0;
    write_status(1'b0, 8'h8C);
    read_status(8'h00, -1);
    write_status(1'b1, 8'hF4);
    read_status(8'hFF, -1);
    cmd(8'h06);
    read_status(8'hFF, -1);
    wait_rdy;
    read_status(8'h84, -1);
    wp_n = ~wp_n; // protect pin now low
    write_status(1'b1, 8'h00);
    read_status(8'h86, -1);
    rdy_on <= 1'b0;
    awr(8'h10, 9);
    `CHK(gos, 1)
    `CHK(waddr, 8'h10)
    `CHK(drop, 1'b1)
    mst.tk(WC + 100);
    `CHK(busy, 1'b1)
    rdy_on <= 1'b1;
    wait_rdy;
    `CHK(got.size(), 8)
    for (int i = 0; i < 8; i++) `CHK(got[i], 8'h30 + 8'(i))
    `CHK(wvalid, 1'b0)
    wp_n = ~wp_n; // protect pin back high
    for (int lv = 0; lv < 4; lv++) begin
      write_status(1'b1, {4'h0, 2'(lv), 2'h0});
      wait_rdy;
      for (int k = 0; k < 6; k++) begin
        g = gos;
        awr(adr[k], 1);
        wait_rdy;
        `CHK(gos - g, prot(lv, adr[k]) ? 0 : 1)
      end
    end
    `CHK(drop, 1'b0)
    read_status(8'h0E, 3);
    end_sim();
  end
endmodule
